/* rtl/wute_engine.sv */
// Waveform update timing engine with APB register slave
`timescale 1ns/1ps
`include "wute_defines.svh"
module wute_engine
    import wute_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] pfi_in,
    output logic [15:0] pfi_out,
    output logic [15:0] pfi_oe,
    output logic converter_update
);
    localparam int CW = `WUTE_CNT_WIDTH;

    // Software-visible registers
    logic [`WUTE_CTRL_WIDTH-1:0] ctrl_reg;
    logic [`WUTE_SRC_WIDTH-1:0] src_reg;
    logic [CW-1:0] divisor;
    logic [CW-1:0] delay;
    logic [CW-1:0] count;
    logic [`WUTE_ROUTE_WIDTH-1:0] route;
    logic [CW-1:0] updates;
    logic done;

    wute_ctrl_t ctrl;
    wute_src_t src;
    wute_state_t state;
    wute_state_t next_state;

    logic [7:0] pin_sync;
    logic [7:0] pin_in;
    logic [`WUTE_SLOW_CNT_WIDTH-1:0] slow_cnt;
    logic slow_tick;
    logic div_tick;
    logic div_pin_edge;
    logic ext_strobe_edge;
    logic launch_pin_edge;
    logic hold_level_now;
    logic hold_active;
    logic [CW-1:0] tick_cnt;
    logic int_strobe;
    logic strobe_event;
    logic launch;
    logic sw_launch;
    logic sw_stop;
    logic sw_arm;
    logic finite_end;
    logic wr_en;
    logic setup;
    logic mapped;
    logic [31:0] next_prdata;
    logic strobe_out_n;
    logic launch_out;
    logic [CW-1:0] eff_divisor;

    // Decode of control and source fields
    assign ctrl.finite = ctrl_reg[`WUTE_CTRL_FINITE];
    assign ctrl.hw_stop = ctrl_reg[`WUTE_CTRL_HW_STOP];
    assign ctrl.strobe_fall = ctrl_reg[`WUTE_CTRL_STROBE_FALL];
    assign ctrl.hold_en = ctrl_reg[`WUTE_CTRL_HOLD_EN];
    assign ctrl.hold_level = ctrl_reg[`WUTE_CTRL_HOLD_LEVEL];
    assign ctrl.launch_pin_en = ctrl_reg[`WUTE_CTRL_LAUNCH_PIN_EN];
    assign ctrl.launch_fall = ctrl_reg[`WUTE_CTRL_LAUNCH_FALL];
    assign src.div_src = wute_div_src_t'(src_reg[`WUTE_SRC_DIV_LSB +: 2]);
    assign src.strobe_ext = src_reg[`WUTE_SRC_STROBE_EXT];
    assign src.div_pin = src_reg[`WUTE_SRC_DIV_PIN_LSB +: 3];
    assign src.strobe_pin = src_reg[`WUTE_SRC_STROBE_PIN_LSB +: 3];
    assign src.launch_pin = src_reg[`WUTE_SRC_LAUNCH_PIN_LSB +: 3];
    assign src.hold_pin = src_reg[`WUTE_SRC_HOLD_PIN_LSB +: 3];

    // Only input-capable terminals are sampled; index 0..3 and 8..11
    wute_sync #(
        .WIDTH(8)
    ) u_pin_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in({pfi_in[11:8], pfi_in[3:0]}),
        .sync_out(pin_sync)
    );
    assign pin_in = pin_sync;

    // Divider source from a terminal counts its rising edges
    wute_edge u_div_edge (
        .mclk(mclk),
        .reset(reset),
        .level(pin_in[src.div_pin]),
        .fall_sel(1'b0),
        .pulse(div_pin_edge)
    );

    // External strobe with selectable active edge
    wute_edge u_strobe_edge (
        .mclk(mclk),
        .reset(reset),
        .level(pin_in[src.strobe_pin]),
        .fall_sel(ctrl.strobe_fall),
        .pulse(ext_strobe_edge)
    );

    // Launch from a terminal with selectable edge
    wute_edge u_launch_edge (
        .mclk(mclk),
        .reset(reset),
        .level(pin_in[src.launch_pin]),
        .fall_sel(ctrl.launch_fall),
        .pulse(launch_pin_edge)
    );

    // Slow reference: one tick every 200 mclk cycles
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            slow_cnt <= '0;
        end else if (slow_cnt == `WUTE_SLOW_CNT_WIDTH'(`WUTE_SLOW_DIV - 1)) begin
            slow_cnt <= '0;
        end else begin
            slow_cnt <= slow_cnt + 1'b1;
        end
    end
    assign slow_tick = (slow_cnt == `WUTE_SLOW_CNT_WIDTH'(`WUTE_SLOW_DIV - 1));

    // Divider source selection; fast reference is mclk itself
    always_comb begin
        case (src.div_src)
            WUTE_DIV_FAST: div_tick = 1'b1;
            WUTE_DIV_SLOW: div_tick = slow_tick;
            WUTE_DIV_PIN: div_tick = div_pin_edge;
            default: div_tick = 1'b0;
        endcase
    end

    // Hold gate level with selectable active polarity
    assign hold_level_now = pin_in[src.hold_pin] == ctrl.hold_level;
    assign hold_active = ctrl.hold_en & hold_level_now;

    // APB access decode
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign pready = psel & penable;
    always_comb begin
        if (paddr == `WUTE_OFS_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == `WUTE_OFS_SRC || paddr == `WUTE_OFS_DIVISOR) begin
            mapped = 1'b1;
        end else if (paddr == `WUTE_OFS_DELAY || paddr == `WUTE_OFS_COUNT) begin
            mapped = 1'b1;
        end else if (paddr == `WUTE_OFS_CMD || paddr == `WUTE_OFS_ROUTE) begin
            mapped = 1'b1;
        end else if (paddr == `WUTE_OFS_STATUS || paddr == `WUTE_OFS_UPDATES) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = psel & penable & ~mapped;

    // Software commands are single-cycle strobes from a write to CMD
    assign sw_launch = wr_en && paddr == `WUTE_OFS_CMD && pwdata[`WUTE_CMD_LAUNCH];
    assign sw_stop = wr_en && paddr == `WUTE_OFS_CMD && pwdata[`WUTE_CMD_STOP];
    assign sw_arm = wr_en && paddr == `WUTE_OFS_CMD && pwdata[`WUTE_CMD_ARM];

    // Configuration registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= '0;
            src_reg <= '0;
            divisor <= `WUTE_DIVISOR_RESET;
            delay <= `WUTE_DELAY_RESET;
            count <= `WUTE_COUNT_RESET;
            route <= '0;
        end else if (wr_en) begin
            if (paddr == `WUTE_OFS_CTRL) begin
                ctrl_reg <= pwdata[`WUTE_CTRL_WIDTH-1:0];
            end else if (paddr == `WUTE_OFS_SRC) begin
                src_reg <= pwdata[`WUTE_SRC_WIDTH-1:0];
            end else if (paddr == `WUTE_OFS_DIVISOR) begin
                divisor <= pwdata[CW-1:0];
            end else if (paddr == `WUTE_OFS_DELAY) begin
                delay <= pwdata[CW-1:0];
            end else if (paddr == `WUTE_OFS_COUNT) begin
                count <= pwdata[CW-1:0];
            end else if (paddr == `WUTE_OFS_ROUTE) begin
                route <= pwdata[`WUTE_ROUTE_WIDTH-1:0];
            end
        end
    end

    // Read data captured in setup so it is stable through the access phase
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (paddr == `WUTE_OFS_CTRL) begin
            next_prdata[`WUTE_CTRL_WIDTH-1:0] = ctrl_reg;
        end else if (paddr == `WUTE_OFS_SRC) begin
            next_prdata[`WUTE_SRC_WIDTH-1:0] = src_reg;
        end else if (paddr == `WUTE_OFS_DIVISOR) begin
            next_prdata[CW-1:0] = divisor;
        end else if (paddr == `WUTE_OFS_DELAY) begin
            next_prdata[CW-1:0] = delay;
        end else if (paddr == `WUTE_OFS_COUNT) begin
            next_prdata[CW-1:0] = count;
        end else if (paddr == `WUTE_OFS_ROUTE) begin
            next_prdata[`WUTE_ROUTE_WIDTH-1:0] = route;
        end else if (paddr == `WUTE_OFS_STATUS) begin
            next_prdata[`WUTE_STAT_ARMED] = (state == WUTE_ARMED);
            next_prdata[`WUTE_STAT_RUNNING] = (state == WUTE_DELAY) || (state == WUTE_RUN);
            next_prdata[`WUTE_STAT_DONE] = done;
        end else if (paddr == `WUTE_OFS_UPDATES) begin
            next_prdata[CW-1:0] = updates;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= next_prdata;
        end
    end

    // Launch from software or from the selected terminal edge
    assign launch = sw_launch | (ctrl.launch_pin_en & launch_pin_edge);

    // A divisor of zero would never fire, so it behaves as one
    assign eff_divisor = (divisor == '0) ? CW'(1) : divisor;

    // Internal strobe when the tick counter reaches its target
    always_comb begin
        int_strobe = 1'b0;
        if (div_tick) begin
            if (state == WUTE_DELAY) begin
                int_strobe = (tick_cnt + CW'(1)) >= delay;
            end else if (state == WUTE_RUN) begin
                int_strobe = (tick_cnt + CW'(1)) >= eff_divisor;
            end
        end
    end

    // Strobe source: internal divider unless external selected; hold masks it
    always_comb begin
        if (src.strobe_ext) begin
            strobe_event = (state == WUTE_RUN) & ext_strobe_edge;
        end else begin
            strobe_event = int_strobe;
        end
        if (hold_active) begin
            strobe_event = 1'b0;
        end
    end

    // Finite run ends with the strobe that reaches the programmed count
    assign finite_end = ctrl.finite && strobe_event && (updates + CW'(1)) >= count;

    // Engine sequence: armed, delay to first strobe (straight to run for an external strobe), then periodic run
    always_comb begin
        next_state = state;
        case (state)
            WUTE_IDLE: begin
                if (sw_arm) begin
                    next_state = WUTE_ARMED;
                end
            end
            WUTE_ARMED: begin
                if (sw_stop) begin
                    next_state = WUTE_IDLE;
                end else if (launch) begin
                    next_state = src.strobe_ext ? WUTE_RUN : WUTE_DELAY;
                end
            end
            WUTE_DELAY: begin
                if (sw_stop) begin
                    next_state = WUTE_IDLE;
                end else if (finite_end && ctrl.hw_stop) begin
                    next_state = WUTE_IDLE;
                end else if (int_strobe) begin
                    next_state = WUTE_RUN;
                end
            end
            WUTE_RUN: begin
                if (sw_stop || (finite_end && ctrl.hw_stop)) begin
                    next_state = WUTE_IDLE;
                end
            end
            default: next_state = WUTE_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state <= WUTE_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Tick counter restarts on launch and after each internal strobe
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tick_cnt <= '0;
        end else if (state == WUTE_ARMED || state == WUTE_IDLE) begin
            tick_cnt <= '0;
        end else if (div_tick) begin
            if (int_strobe) begin
                tick_cnt <= '0;
            end else begin
                tick_cnt <= tick_cnt + CW'(1);
            end
        end
    end

    // Update counter and completion flag; completion wins over a same-cycle arm
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            updates <= '0;
            done <= 1'b0;
        end else begin
            if (state == WUTE_ARMED && launch) begin
                updates <= '0;
            end else if (strobe_event) begin
                updates <= updates + CW'(1);
            end
            if (finite_end) begin
                done <= 1'b1;
            end else if (sw_arm) begin
                done <= 1'b0;
            end
        end
    end

    // One update pulse serves every converter at once
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            converter_update <= 1'b0;
            strobe_out_n <= 1'b1;
            launch_out <= 1'b0;
        end else begin
            converter_update <= strobe_event;
            strobe_out_n <= ~strobe_event;
            launch_out <= (state == WUTE_ARMED) & launch;
        end
    end

    // Output terminals 4..7 and 12..15 carry strobe or launch; divider source has no path
    always_comb begin
        pfi_out = 16'h0000;
        pfi_oe = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            if (route[`WUTE_ROUTE_STROBE_LSB + i]) begin
                pfi_out[(i < 4) ? i + 4 : i + 8] = strobe_out_n;
                pfi_oe[(i < 4) ? i + 4 : i + 8] = 1'b1;
            end else if (route[`WUTE_ROUTE_LAUNCH_LSB + i]) begin
                pfi_out[(i < 4) ? i + 4 : i + 8] = launch_out;
                pfi_oe[(i < 4) ? i + 4 : i + 8] = 1'b1;
            end
        end
    end
endmodule

/* rtl/wute_defines.svh */
// Register offsets, field positions, reset values and timing counts of the update engine
`ifndef WUTE_DEFINES_SVH
`define WUTE_DEFINES_SVH

// Register byte offsets
`define WUTE_OFS_CTRL 8'h00
`define WUTE_OFS_SRC 8'h04
`define WUTE_OFS_DIVISOR 8'h08
`define WUTE_OFS_DELAY 8'h0C
`define WUTE_OFS_COUNT 8'h10
`define WUTE_OFS_CMD 8'h14
`define WUTE_OFS_ROUTE 8'h18
`define WUTE_OFS_STATUS 8'h1C
`define WUTE_OFS_UPDATES 8'h20

// Control register fields
`define WUTE_CTRL_FINITE 0
`define WUTE_CTRL_HW_STOP 1
`define WUTE_CTRL_STROBE_FALL 2
`define WUTE_CTRL_HOLD_EN 3
`define WUTE_CTRL_HOLD_LEVEL 4
`define WUTE_CTRL_LAUNCH_PIN_EN 5
`define WUTE_CTRL_LAUNCH_FALL 6
`define WUTE_CTRL_WIDTH 7

// Source register fields
`define WUTE_SRC_DIV_LSB 0
`define WUTE_SRC_STROBE_EXT 2
`define WUTE_SRC_DIV_PIN_LSB 3
`define WUTE_SRC_STROBE_PIN_LSB 6
`define WUTE_SRC_LAUNCH_PIN_LSB 9
`define WUTE_SRC_HOLD_PIN_LSB 12
`define WUTE_SRC_WIDTH 15

// Command register fields
`define WUTE_CMD_LAUNCH 0
`define WUTE_CMD_STOP 1
`define WUTE_CMD_ARM 2

// Route register fields: strobe mask low byte, launch mask high byte
`define WUTE_ROUTE_STROBE_LSB 0
`define WUTE_ROUTE_LAUNCH_LSB 8
`define WUTE_ROUTE_WIDTH 16

// Status register fields
`define WUTE_STAT_ARMED 0
`define WUTE_STAT_RUNNING 1
`define WUTE_STAT_DONE 2

// Counter widths and reset values
`define WUTE_CNT_WIDTH 24
`define WUTE_DIVISOR_RESET 24'h00_0002
`define WUTE_DELAY_RESET 24'h00_0002
`define WUTE_COUNT_RESET 24'h00_0001

// Reference rates; the slow reference is a division of mclk
`define WUTE_MCLK_HZ 20000000
`define WUTE_SLOW_REF_HZ 100000
`define WUTE_SLOW_DIV (`WUTE_MCLK_HZ / `WUTE_SLOW_REF_HZ)
`define WUTE_SLOW_CNT_WIDTH 8

`endif

/* rtl/wute_pkg.sv */
// Types shared by the update engine files
package wute_pkg;
    // Divider source choice
    typedef enum logic [1:0] {
        WUTE_DIV_FAST,
        WUTE_DIV_SLOW,
        WUTE_DIV_PIN
    } wute_div_src_t;

    // Engine states
    typedef enum logic [1:0] {
        WUTE_IDLE,
        WUTE_ARMED,
        WUTE_DELAY,
        WUTE_RUN
    } wute_state_t;

    // Decoded control bits
    typedef struct packed {
        logic finite;
        logic hw_stop;
        logic strobe_fall;
        logic hold_en;
        logic hold_level;
        logic launch_pin_en;
        logic launch_fall;
    } wute_ctrl_t;

    // Decoded source selections
    typedef struct packed {
        wute_div_src_t div_src;
        logic strobe_ext;
        logic [2:0] div_pin;
        logic [2:0] strobe_pin;
        logic [2:0] launch_pin;
        logic [2:0] hold_pin;
    } wute_src_t;
endpackage

/* rtl/wute_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module wute_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

/* rtl/wute_edge.sv */
// Edge detector with selectable rising or falling edge
`timescale 1ns/1ps
module wute_edge (
    input wire logic mclk,
    input wire logic reset,
    input wire logic level,
    input wire logic fall_sel,
    output logic pulse
);
    logic prev;

    // Previous level, cleared at reset so a level high on release is seen as a rising edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign pulse = fall_sel ? (prev & ~level) : (~prev & level);
endmodule

/* dv/wute_engine_chk_properties.sv */
// Port checker for the update engine, bound to its top module
`timescale 1ns/1ps
module wute_engine_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] pfi_out,
    input wire logic [15:0] pfi_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    // Input-only terminals stay undriven, so the divider source cannot leak out
    a_oe_out_only: assert property ((pfi_oe & 16'h0F0F) == 16'h0000)
        else $error("enable on an input-only terminal");
    a_drive_out_only: assert property ((pfi_out & 16'h0F0F) == 16'h0000)
        else $error("level on an input-only terminal");
    // Zero wait states: ready tracks the access phase exactly
    a_ready_access: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
    a_ready_idle: assert property (!(psel && penable) |-> !pready)
        else $error("ready outside access phase");
    a_err_scope: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    a_err_unmapped: assert property (psel && penable && paddr > 8'h20 |-> pslverr)
        else $error("unmapped access not refused");
    a_ok_mapped: assert property (psel && penable && paddr <= 8'h20 && paddr[1:0] == 2'b00
        |-> !pslverr)
        else $error("mapped access refused");
    // Read data is captured at setup only and held otherwise
    a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved outside setup");
    a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 8'h20
        |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    // Terminal enables come from the route register, so only a write moves them
    a_oe_on_write: assert property (!$stable(pfi_oe) |-> $past(psel) && $past(penable) && $past(pwrite))
        else $error("enables changed without a write");
endmodule

bind wute_engine wute_engine_chk wute_engine_chk_i (
    .mclk, .reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .pfi_out, .pfi_oe
);

/* dv/wute_far_end.sv */
// Far-side sources: external clock, launch trigger and hold gate on input terminals
`timescale 1ns/1ps
module wute_far_end #(
    parameter int HALF = 2
) (
    input wire logic mclk,
    input wire logic clk_run,
    input wire logic trig_lvl,
    input wire logic hold_lvl,
    output logic [15:0] pfi_in
);
    int ph = 0;
    logic ext_clk = 1'b0;
    logic [15:0] junk = 16'h5A3C;
    // Clock runs only in bursts and rests low between them
    always @(posedge mclk) begin
        junk <= junk + 16'h3B1D;
        if (!clk_run) begin
            ph <= 0;
            ext_clk <= 1'b0;
        end else if (ph == HALF - 1) begin
            ph <= 0;
            ext_clk <= ~ext_clk;
        end else begin
            ph <= ph + 1;
        end
    end
    // Unused terminals change every cycle so no stale level looks valid
    always_comb begin
        pfi_in = junk;
        pfi_in[1] = trig_lvl;
        pfi_in[2] = hold_lvl;
        pfi_in[8] = ext_clk;
    end
endmodule

/* dv/waveform_update_timing_engine_tb.sv */
// Self-checking bench for the waveform update timing engine
`timescale 1ns/1ps
`include "wute_defines.svh"
module waveform_update_timing_engine_tb;
    localparam int HALF = 2;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] pfi_in;
    logic [15:0] pfi_out;
    logic [15:0] pfi_oe;
    logic converter_update;
    logic clk_run = 1'b0;
    logic trig_lvl = 1'b0;
    logic hold_lvl = 1'b0;
    logic oe5_d = 1'b0;
    logic [31:0] rd;
    logic er;
    logic [31:0] rv [9] = '{0, 0, 2, 2, 1, 0, 0, 0, 0};
    int num_errors = 0;
    int n_checks = 0;
    int seed = 79617;
    int cyc = 0;
    int tl = 0;
    int n_lp = 0;
    int ut[$];

    wute_engine wute_engine_i (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pfi_in(pfi_in), .pfi_out(pfi_out), .pfi_oe(pfi_oe),
        .converter_update(converter_update)
    );
    wute_far_end #(.HALF(HALF)) wute_far_end_i (
        .mclk(mclk), .clk_run(clk_run), .trig_lvl(trig_lvl), .hold_lvl(hold_lvl),
        .pfi_in(pfi_in)
    );

    // 20 MHz clock
    initial begin
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask

    task automatic summarize();
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One APB transfer; the request is held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    function automatic int exp_gap(input int div);
        return (div == 0) ? 1 : div;
    endfunction

    function automatic int exp_lat(input int dly);
        return ((dly < 2) ? 1 : dly) + 1;
    endfunction

    // Configure, arm and optionally launch by command; a negative divisor or delay skips that write and keeps the current value
    task automatic go(input int ctrl, input int src, input int div, input int dly,
                      input int cnt, input logic sw);
        ut.delete();
        wr(`WUTE_OFS_CTRL, ctrl);
        wr(`WUTE_OFS_SRC, src);
        if (div >= 0) wr(`WUTE_OFS_DIVISOR, div);
        if (dly >= 0) wr(`WUTE_OFS_DELAY, dly);
        wr(`WUTE_OFS_COUNT, cnt);
        wr(`WUTE_OFS_CMD, 32'h0000_0004);
        if (sw) wr(`WUTE_OFS_CMD, 32'h0000_0001);
        tl = cyc;
    endtask

    task automatic times(input string nm, input int lat, input int gap, input int n);
        chk({nm, " count"}, n, ut.size());
        if (ut.size() > 0 && lat >= 0) chk({nm, " latency"}, lat, ut[0] - tl);
        for (int i = 1; i < ut.size(); i++) chk({nm, " gap"}, gap, ut[i] - ut[i - 1]);
    endtask

    // Update moments, launch pulses and the strobe terminal level
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        oe5_d <= pfi_oe[5];
        if (converter_update === 1'b1) ut.push_back(cyc);
        if (pfi_oe[4] && pfi_out[4] === 1'b1) n_lp <= n_lp + 1;
        if (oe5_d && pfi_oe[5]) chk("strobe pin", !converter_update, pfi_out[5]);
    end

    // Hang guard
    initial begin
        settle(20000);
        num_errors++;
        summarize();
    end

    initial begin
        int div;
        int dly;
        int cnt;
        int lat [2];
        settle(12);
        reset <= 1'b0;
        // Reset values, unused bits and refused addresses
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk("reset value", rv[i], rd);
            chk("mapped", 0, er);
        end
        wr(8'h24, 32'hFFFF_FFFF);
        chk("unmapped write", 1, er);
        apb(1'b0, 8'h24, 32'h0000_0000);
        chk("unmapped read", 0, rd);
        wr(`WUTE_OFS_ROUTE, 32'h0000_0102);
        settle(1);
        chk("route enables", 32'h0000_0030, pfi_oe);
        // Defaults: two-tick delay, divide by two, finite run ended by hardware
        go(3, 0, -1, -1, 3, 1'b1);
        settle(30);
        times("default", 3, 2, 3);
        apb(1'b0, `WUTE_OFS_STATUS, 32'h0000_0000);
        chk("status done", 32'h0000_0004, rd);
        apb(1'b0, `WUTE_OFS_UPDATES, 32'h0000_0000);
        chk("update total", 3, rd);
        chk("launch pulses", 1, n_lp);
        // Finite run without hardware stop keeps running until the stop command
        go(1, 0, 2, 2, 2, 1'b1);
        settle(20);
        apb(1'b0, `WUTE_OFS_STATUS, 32'h0000_0000);
        chk("finite running", 32'h0000_0006, rd);
        wr(`WUTE_OFS_CMD, 32'h0000_0002);
        apb(1'b0, `WUTE_OFS_STATUS, 32'h0000_0000);
        chk("software stop", 32'h0000_0004, rd);
        // Fast reference: corner values first, then random ones
        for (int k = 0; k < 5; k++) begin
            div = (k == 0) ? 1 : $unsigned($random(seed)) % 6;
            dly = (k == 0) ? 0 : $unsigned($random(seed)) % 6;
            cnt = 1 + $unsigned($random(seed)) % 4;
            go(3, 0, div, dly, cnt, 1'b1);
            settle(dly + 6 * cnt + 10);
            times("fast", exp_lat(dly), exp_gap(div), cnt);
        end
        // Slow reference and terminal clock as divider source
        go(3, 1, 1, 2, 3, 1'b1);
        settle(1100);
        times("slow", -1, `WUTE_SLOW_DIV, 3);
        clk_run <= 1'b1;
        go(3, 32'h0000_0022, 3, 2, 3, 1'b1);
        settle(80);
        times("pin source", -1, 3 * 2 * HALF, 3);
        clk_run <= 1'b0;
        // High-active hold gate, then a stop command
        hold_lvl <= 1'b1;
        go(24, 32'h0000_2000, 2, 2, 1, 1'b1);
        settle(40);
        chk("held", 0, ut.size());
        hold_lvl <= 1'b0;
        settle(40);
        chk("released", 1, ut.size() > 10);
        wr(`WUTE_OFS_CMD, 32'h0000_0002);
        settle(5);
        cnt = ut.size();
        settle(40);
        chk("after stop", cnt, ut.size());
        // External strobe: the falling choice lags the rising one by half a period
        for (int e = 0; e < 2; e++) begin
            go(3 + 4 * e, 32'h0000_0104, 2, 2, 4, 1'b1);
            clk_run <= 1'b1;
            settle(40);
            clk_run <= 1'b0;
            times("external", -1, 2 * HALF, 4);
            lat[e] = ut[0] - tl;
        end
        chk("edge choice", HALF, lat[1] - lat[0]);
        // Launch from a terminal edge; the opposite edge must not start the run
        for (int e = 0; e < 2; e++) begin
            trig_lvl <= (e == 0);
            go(35 + 64 * e, 32'h0000_0200, 2, 2, 1, 1'b0);
            cnt = n_lp;
            trig_lvl <= (e == 1);
            settle(10);
            chk("wrong edge", 0, ut.size());
            trig_lvl <= (e == 0);
            settle(15);
            chk("pin launch", 1, ut.size());
            chk("launch pulse", cnt + 1, n_lp);
        end
        summarize();
    end
endmodule
